//--- pkg/i2csf_pkg.sv
package i2csf_pkg;

  // ****************************************************************
  // Bus map and field layout
  // ****************************************************************
  localparam int unsigned AW          = 8;
  localparam logic [7:0]  ADR_STATUS  = 8'h00;
  localparam logic [7:0]  ADR_VECTOR  = 8'h04;
  localparam logic [7:0]  ADR_MASK    = 8'h08;
  localparam logic [7:0]  ADR_MODE    = 8'h0C;
  localparam logic [7:0]  ADR_TXDATA  = 8'h10;
  localparam logic [7:0]  ADR_RXDATA  = 8'h14;

  localparam int unsigned BIT_SCD     = 5;
  localparam int unsigned BIT_TRANSMIT_READY_REQUEST    = 4;
  localparam int unsigned BIT_RECEIVE_READY_REQUEST    = 3;
  localparam int unsigned BIT_REGISTER_ACCESS_READY_FLAG    = 2;

  localparam int unsigned BIT_IRS     = 5;
  localparam int unsigned BIT_RM      = 7;
  localparam int unsigned BIT_MST     = 10;
  localparam int unsigned BIT_STP     = 11;
  localparam logic [31:0] MODE_WMASK  = 32'h0000_0CA0;
  localparam logic [31:0] MODE_RST    = 32'h0000_0000;
  localparam logic [31:0] MASK_WMASK  = 32'h0000_003C;
  localparam logic [31:0] MASK_RST    = 32'h0000_0000;

  // ****************************************************************
  // Interrupt source codes
  // ****************************************************************
  localparam logic [2:0]  CODE_NONE   = 3'h0;
  localparam logic [2:0]  CODE_REGISTER_ACCESS_READY_FLAG   = 3'h3;
  localparam logic [2:0]  CODE_RECEIVE_READY_REQUEST   = 3'h4;
  localparam logic [2:0]  CODE_TRANSMIT_READY_REQUEST   = 3'h5;
  localparam logic [2:0]  CODE_SCD    = 3'h6;

  localparam int unsigned NPIN        = 2;
  localparam int unsigned PIN_SCL     = 0;
  localparam int unsigned PIN_SDA     = 1;

  typedef struct packed {
    logic stop_detected_flag;
    logic transmit_ready_request;
    logic receive_ready_request;
    logic register_access_ready_flag;
  } i2csf_flags_t;

endpackage

//--- verif/i2csf_bus_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Other device on the two-wire bus
// ****************************************************************
module i2csf_bus_model (
  input  wire logic i_go,
  output logic      o_scl,
  output logic      o_sda
);
  // Pull-ups keep both lines high outside frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Short frame of START then STOP, 125 ns link clock
  always @(posedge i_go) begin
    o_sda = 1'b0;
    #62.5 o_scl = 1'b0;
    #62.5 o_scl = 1'b1;
    #62.5 o_sda = 1'b1;
  end
endmodule // i2csf_bus_model

//--- verif/testbench.sv
`timescale 1ns/1ps

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
  import i2csf_pkg::*;

  typedef struct packed {
    logic [31:0] mode;
    logic [5:0]  ev1;
    logic [5:0]  ev2;
    logic [3:0]  exp;
    logic        stop_request_bit;
  } i2csf_row_t;

  // Event bits: 0 copy, 1 rx load, 2 addr, 3 regs used, 4 count zero, 5 word done
  localparam i2csf_row_t ROWS [7] = '{
    '{32'h0000_0420, 6'h01, 6'h00, 4'h4, 1'b0},
    '{32'h0000_0420, 6'h02, 6'h00, 4'h2, 1'b0},
    '{32'h0000_0420, 6'h04, 6'h10, 4'h1, 1'b0},
    '{32'h0000_04A0, 6'h04, 6'h20, 4'h1, 1'b0},
    '{32'h0000_0C20, 6'h04, 6'h10, 4'h0, 1'b1},
    '{32'h0000_0020, 6'h04, 6'h10, 4'h0, 1'b0},
    '{32'h0000_0420, 6'h00, 6'h10, 4'h0, 1'b0}
  };

  logic         ref_clk = 1'b0;
  logic         rst = 1'b1;
  logic         cyc = 1'b0;
  logic         stb = 1'b0;
  logic         we = 1'b0;
  logic [7:0]   adr = 8'h00;
  logic [31:0]  dat = 32'h0;
  logic [5:0]   ev = 6'h00;
  logic [7:0]   rx_byte = 8'h00;
  logic         stop_go = 1'b0;
  logic         scl;
  logic         sda;
  logic [31:0]  rdat;
  logic         ack;
  logic [7:0]   tx_data;
  logic         stop_gen, run, mst, rpt, stp_req;
  i2csf_flags_t req;
  logic [31:0]  q;
  int           n_mismatch = 0;
  int           samples_checked = 0;

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  i2csf_bus_model peer (.i_go(stop_go), .o_scl(scl), .o_sda(sda));

  i2csf_status #(.DW(8)) uut (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_scl(scl), .i_sda(sda), .i_tx_copied(ev[0]), .i_rx_loaded(ev[1]),
    .i_rx_byte(rx_byte), .i_addr_sent(ev[2]), .i_regs_used(ev[3]), .i_cnt_zero(ev[4]),
    .i_word_done(ev[5]), .o_tx_data(tx_data), .o_stop_gen(stop_gen), .o_module_run(run),
    .o_master(mst), .o_repeat(rpt), .o_stop_req(stp_req), .o_requests(req));

  // ****************************************************************
  // Bus and event tasks
  // ****************************************************************
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge ref_clk);
    while (ack !== 1'b1) begin
      @(posedge ref_clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic pulse(input logic [5:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 6'h00;
  endtask

  task automatic flags_are(input logic [3:0] e);
    wb(1'b0, ADR_STATUS, 32'h0);
    `CHK(q[5:2], e)
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    flags_are(4'h4);
    wb(1'b0, ADR_MODE, 32'h0);
    `CHK(q, MODE_RST)
    wb(1'b0, ADR_MASK, 32'h0);
    `CHK(q, MASK_RST)
    pulse(6'h02);
    flags_are(4'h4);
    wb(1'b1, ADR_MASK, 32'h0000_003C);
    wb(1'b1, 8'hFC, 32'hFFFF_FFFF);
    wb(1'b0, 8'hFC, 32'h0);
    `CHK(q, 32'h0)
    foreach (ROWS[i]) begin
      wb(1'b1, ADR_MODE, 32'h0);
      wb(1'b1, ADR_MODE, ROWS[i].mode);
      wb(1'b1, ADR_STATUS, 32'h0000_003C);
      pulse(ROWS[i].ev1);
      pulse(ROWS[i].ev2);
      #1;
      `CHK(stop_gen, ROWS[i].stop_request_bit)
      flags_are(ROWS[i].exp);
      `CHK(req, ROWS[i].exp)
      `CHK({stp_req, mst, rpt, run}, {ROWS[i].mode[BIT_STP], ROWS[i].mode[BIT_MST], ROWS[i].mode[BIT_RM], ROWS[i].mode[BIT_IRS]})
    end
    pulse(6'h01);
    wb(1'b1, ADR_TXDATA, 32'h0000_00A5);
    #1;
    `CHK(tx_data, 8'hA5)
    flags_are(4'h0);
    rx_byte <= 8'h5A;
    pulse(6'h02);
    wb(1'b0, ADR_RXDATA, 32'h0);
    `CHK(q[7:0], 8'h5A)
    flags_are(4'h0);
    pulse(6'h04);
    pulse(6'h10);
    pulse(6'h08);
    flags_are(4'h0);
    pulse(6'h01);
    pulse(6'h10);
    wb(1'b1, ADR_STATUS, 32'h0000_0014);
    flags_are(4'h0);
    fork
      wb(1'b1, ADR_STATUS, 32'h0000_0008);
      begin
        repeat (2) @(posedge ref_clk);
        ev <= 6'h02;
        @(posedge ref_clk);
        ev <= 6'h00;
      end
    join
    flags_are(4'h2);
    wb(1'b0, ADR_VECTOR, 32'h0);
    `CHK(q[2:0], CODE_RECEIVE_READY_REQUEST)
    wb(1'b1, ADR_MASK, 32'h0000_0020);
    #1;
    `CHK(req, 4'h0)
    flags_are(4'h2);
    wb(1'b1, ADR_MASK, 32'h0000_003C);
    wb(1'b1, ADR_STATUS, 32'h0000_0008);
    flags_are(4'h0);
    for (int s = 0; s < 2; s++) begin
      stop_go <= 1'b1;
      repeat (40) @(posedge ref_clk);
      stop_go <= 1'b0;
      flags_are(4'h8);
      wb(s[0], s[0] ? ADR_STATUS : ADR_VECTOR, 32'h0000_0020);
      if (s == 0) `CHK(q[2:0], CODE_SCD)
      flags_are(4'h0);
    end
    pulse(6'h02);
    wb(1'b1, ADR_MODE, 32'h0);
    flags_are(4'h4);
    wb(1'b1, ADR_MODE, 32'h0000_0420);
    pulse(6'h02);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    flags_are(4'h4);
    wb(1'b0, ADR_MODE, 32'h0);
    `CHK(q, MODE_RST)
    tally_and_finish();
  end

  // Whole sequence needs roughly 330 cycles
  initial begin
    #500000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule // testbench

//--- verilog/i2csf_status.sv
`timescale 1ns/1ps

// Operation
// - Vector read with stop code clears stop flag
// - Writing one clears stop flag
// - Detected STOP sets stop flag
// - Any STOP on bus counts
// - Copy to shift register sets transmit ready
// - Transmit data write clears transmit ready
// - Writing one clears transmit ready
// - Transmit ready forced high in reset
// - Receive copy sets receive ready
// - Receive data read clears receive ready
// - Writing one clears receive ready
// - Module or processor reset clears flags other than transmit ready
// - Access ready only in master mode
// - Starting register use clears access ready
// - Writing one clears access ready
// - Access ready set only after address
// - Non-repeat, no stop: counter zero sets
// - Non-repeat, stop: counter zero issues STOP
// - Repeat mode: each word sets access ready
// - Each flag pollable and drives request
module i2csf_status
  import i2csf_pkg::*;
#(
  parameter int unsigned DW = 8
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst,
  input  wire logic          i_wb_cyc,
  input  wire logic          i_wb_stb,
  input  wire logic          i_wb_we,
  input  wire logic [AW-1:0] i_wb_adr,
  input  wire logic [3:0]    i_wb_sel,
  input  wire logic [31:0]   i_wb_dat,
  output logic      [31:0]   o_wb_dat,
  output logic               o_wb_ack,
  input  wire logic          i_scl,
  input  wire logic          i_sda,
  input  wire logic          i_tx_copied,
  input  wire logic          i_rx_loaded,
  input  wire logic [DW-1:0] i_rx_byte,
  input  wire logic          i_addr_sent,
  input  wire logic          i_regs_used,
  input  wire logic          i_cnt_zero,
  input  wire logic          i_word_done,
  output logic      [DW-1:0] o_tx_data,
  output logic               o_stop_gen,
  output logic               o_module_run,
  output logic               o_master,
  output logic               o_repeat,
  output logic               o_stop_req,
  output i2csf_flags_t       o_requests
);

  // ****************************************************************
  // Bus slave decode
  // ****************************************************************
  logic         ack_ff;
  logic [31:0]  rdat_ff;
  logic [31:0]  mode_ff;
  logic [31:0]  mask_ff;
  logic [DW-1:0] txd_ff;
  logic [DW-1:0] rxd_ff;
  i2csf_flags_t flags_ff;
  logic         addr_seen_ff;
  logic         stopgen_ff;

  wire       req      = i_wb_cyc & i_wb_stb;
  wire       rd_take  = req & ~i_wb_we & ~ack_ff;
  wire       wr_take  = req & i_wb_we & ack_ff;
  wire [31:0] bmask   = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                         {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  wire [31:0] wdat    = i_wb_dat & bmask;

  wire hit_status = i_wb_adr == ADR_STATUS;
  wire hit_vector = i_wb_adr == ADR_VECTOR;
  wire hit_mask   = i_wb_adr == ADR_MASK;
  wire hit_mode   = i_wb_adr == ADR_MODE;
  wire hit_txdata = i_wb_adr == ADR_TXDATA;
  wire hit_rxdata = i_wb_adr == ADR_RXDATA;

  wire wr_status  = wr_take & hit_status;
  wire wr_mask    = wr_take & hit_mask;
  wire wr_mode    = wr_take & hit_mode;
  wire wr_txdata  = wr_take & hit_txdata & i_wb_sel[0];
  wire rd_vector  = rd_take & hit_vector;
  wire rd_rxdata  = rd_take & hit_rxdata;

  // ****************************************************************
  // Mode fields
  // ****************************************************************
  wire mod_run = mode_ff[BIT_IRS];
  wire rm      = mode_ff[BIT_RM];
  wire mst     = mode_ff[BIT_MST];
  wire stop_request_bit     = mode_ff[BIT_STP];

  // ****************************************************************
  // Pin synchronisers and STOP detector
  // ****************************************************************
  logic [NPIN-1:0] pin_s1_ff;
  logic [NPIN-1:0] pin_s2_ff;
  logic [NPIN-1:0] pin_s3_ff;
  logic [NPIN-1:0] pin_lvl_ff;
  logic [NPIN-1:0] pin_old_ff;
  wire  [NPIN-1:0] pin_in = {i_sda, i_scl};

  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp++) begin : g_pin
      // Level only moves once two later stages agree
      wire nxt_lvl = (pin_s2_ff[gp] == pin_s3_ff[gp]) ? pin_s3_ff[gp]
                                                       : pin_lvl_ff[gp];
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          pin_s1_ff[gp]  <= 1'b1;
          pin_s2_ff[gp]  <= 1'b1;
          pin_s3_ff[gp]  <= 1'b1;
          pin_lvl_ff[gp] <= 1'b1;
          pin_old_ff[gp] <= 1'b1;
        end else begin
          pin_s1_ff[gp]  <= pin_in[gp];
          pin_s2_ff[gp]  <= pin_s1_ff[gp];
          pin_s3_ff[gp]  <= pin_s2_ff[gp];
          pin_lvl_ff[gp] <= nxt_lvl;
          pin_old_ff[gp] <= pin_lvl_ff[gp];
        end
      end
    end
  endgenerate

  // Data rising while clock stays high, whoever drove it
  wire stop_det = pin_lvl_ff[PIN_SDA] & ~pin_old_ff[PIN_SDA]
                & pin_lvl_ff[PIN_SCL] & pin_old_ff[PIN_SCL];

  // ****************************************************************
  // Interrupt vector
  // ****************************************************************
  i2csf_flags_t en;
  assign en = flags_ff & i2csf_flags_t'(mask_ff[BIT_SCD:BIT_REGISTER_ACCESS_READY_FLAG]);

  wire [2:0] vec_code = en.register_access_ready_flag ? CODE_REGISTER_ACCESS_READY_FLAG :
                        en.receive_ready_request ? CODE_RECEIVE_READY_REQUEST :
                        en.transmit_ready_request ? CODE_TRANSMIT_READY_REQUEST :
                        en.stop_detected_flag  ? CODE_SCD  : CODE_NONE;

  // ****************************************************************
  // Flag set and clear terms
  // ****************************************************************
  wire clr_scd  = (wr_status & wdat[BIT_SCD])
                | (rd_vector & (vec_code == CODE_SCD));
  wire clr_transmit_ready_request = (wr_status & wdat[BIT_TRANSMIT_READY_REQUEST]) | wr_txdata;
  wire clr_receive_ready_request = (wr_status & wdat[BIT_RECEIVE_READY_REQUEST]) | rd_rxdata;
  wire clr_register_access_ready_flag = (wr_status & wdat[BIT_REGISTER_ACCESS_READY_FLAG]) | i_regs_used;

  // Counter end either raises the flag or asks for STOP
  wire cnt_set  = ~rm & ~stop_request_bit & i_cnt_zero;
  wire word_set = rm & i_word_done;
  wire set_register_access_ready_flag = mst & addr_seen_ff & (cnt_set | word_set);
  wire nxt_stopgen = mod_run & mst & ~rm & stop_request_bit & i_cnt_zero;

  // Set terms are ORed last so they beat a clear in the same cycle
  i2csf_flags_t nxt_flags;
  assign nxt_flags.stop_detected_flag  = stop_det | (flags_ff.stop_detected_flag & ~clr_scd);
  assign nxt_flags.transmit_ready_request = i_tx_copied | (flags_ff.transmit_ready_request & ~clr_transmit_ready_request);
  assign nxt_flags.receive_ready_request = i_rx_loaded | (flags_ff.receive_ready_request & ~clr_receive_ready_request);
  assign nxt_flags.register_access_ready_flag = set_register_access_ready_flag | (flags_ff.register_access_ready_flag & ~clr_register_access_ready_flag);

  wire nxt_addr_seen = mst & (i_addr_sent | addr_seen_ff);

  // ****************************************************************
  // Read mux
  // ****************************************************************
  wire [31:0] status_word = (32'(flags_ff.stop_detected_flag)  << BIT_SCD)
                          | (32'(flags_ff.transmit_ready_request) << BIT_TRANSMIT_READY_REQUEST)
                          | (32'(flags_ff.receive_ready_request) << BIT_RECEIVE_READY_REQUEST)
                          | (32'(flags_ff.register_access_ready_flag) << BIT_REGISTER_ACCESS_READY_FLAG);
  wire [31:0] nxt_rdat =
      hit_status ? status_word :
      hit_vector ? 32'(vec_code) :
      hit_mask   ? mask_ff :
      hit_mode   ? mode_ff :
      hit_txdata ? 32'(txd_ff) :
      hit_rxdata ? 32'(rxd_ff) : 32'h0000_0000;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff  <= req & ~ack_ff;
      rdat_ff <= rd_take ? nxt_rdat : rdat_ff;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      mode_ff <= MODE_RST;
      mask_ff <= MASK_RST;
      txd_ff  <= '0;
    end else begin
      if (wr_mode) begin
        mode_ff <= (mode_ff & ~(bmask & MODE_WMASK)) | (wdat & MODE_WMASK);
      end
      if (wr_mask) begin
        mask_ff <= (mask_ff & ~(bmask & MASK_WMASK)) | (wdat & MASK_WMASK);
      end
      if (wr_txdata) begin
        txd_ff <= wdat[DW-1:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      flags_ff     <= '{stop_detected_flag: 1'b0, transmit_ready_request: 1'b1, receive_ready_request: 1'b0, register_access_ready_flag: 1'b0};
      addr_seen_ff <= 1'b0;
      stopgen_ff   <= 1'b0;
    end else if (!mod_run) begin
      flags_ff     <= '{stop_detected_flag: 1'b0, transmit_ready_request: 1'b1, receive_ready_request: 1'b0, register_access_ready_flag: 1'b0};
      addr_seen_ff <= 1'b0;
      stopgen_ff   <= 1'b0;
    end else begin
      flags_ff     <= nxt_flags;
      addr_seen_ff <= nxt_addr_seen & ~stop_det;
      stopgen_ff   <= nxt_stopgen;
    end
  end

  // Receive data is kept even in module reset so software may drain it
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rxd_ff <= '0;
    end else if (i_rx_loaded) begin
      rxd_ff <= i_rx_byte;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_wb_ack     = ack_ff;
  assign o_wb_dat     = rdat_ff;
  assign o_tx_data    = txd_ff;
  assign o_stop_gen   = stopgen_ff;
  assign o_module_run = mod_run;
  assign o_master     = mst;
  assign o_repeat     = rm;
  assign o_stop_req   = stop_request_bit;
  assign o_requests   = en;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_stop_on_bus;
    pin_lvl_ff[PIN_SCL] & ~pin_lvl_ff[PIN_SDA]
    ##1 pin_lvl_ff[PIN_SCL] & pin_lvl_ff[PIN_SDA];
  endsequence

  sequence s_count_end_stp;
    mod_run & mst & ~rm & stop_request_bit & i_cnt_zero;
  endsequence

  stop_sets_scd_a: assert property (
    s_stop_on_bus ##0 mod_run |=> flags_ff.stop_detected_flag)
    else $error("stop did not set stop flag");

  scd_w1c_a: assert property (
    mod_run & wr_status & wdat[BIT_SCD] & ~stop_det |=> ~flags_ff.stop_detected_flag)
    else $error("stop flag not cleared by write one");

  scd_vector_a: assert property (
    mod_run & rd_vector & (vec_code == CODE_SCD) & ~stop_det
    |=> ~flags_ff.stop_detected_flag ##1 o_wb_dat[2:0] == CODE_SCD)
    else $error("vector read did not clear stop flag");

  transmit_ready_request_reset_a: assert property (
    ~mod_run |=> flags_ff.transmit_ready_request & ~flags_ff.receive_ready_request & ~flags_ff.register_access_ready_flag)
    else $error("flags wrong in module reset");

  transmit_ready_request_write_a: assert property (
    mod_run & wr_txdata & ~i_tx_copied |=> ~flags_ff.transmit_ready_request
    && o_tx_data == $past(i_wb_dat[DW-1:0]))
    else $error("transmit write did not clear ready");

  receive_ready_request_load_a: assert property (
    mod_run & i_rx_loaded |=> flags_ff.receive_ready_request && rxd_ff == $past(i_rx_byte))
    else $error("receive copy did not set ready");

  receive_ready_request_read_a: assert property (
    mod_run & rd_rxdata & ~i_rx_loaded |=> ~flags_ff.receive_ready_request)
    else $error("receive read did not clear ready");

  set_wins_a: assert property (
    mod_run & clr_receive_ready_request & i_rx_loaded |=> flags_ff.receive_ready_request)
    else $error("clear beat a set");

  register_access_ready_flag_addr_a: assert property (
    $rose(flags_ff.register_access_ready_flag) |-> $past(addr_seen_ff) & $past(mst))
    else $error("access ready set before address");

  stop_issue_a: assert property (
    s_count_end_stp |=> o_stop_gen & (flags_ff.register_access_ready_flag == $past(flags_ff.register_access_ready_flag)
    || $past(clr_register_access_ready_flag)))
    else $error("stop request not issued at count end");

  register_access_ready_flag_repeat_a: assert property (
    mod_run & mst & rm & addr_seen_ff & i_word_done |=> flags_ff.register_access_ready_flag)
    else $error("repeat word did not set access ready");

  wb_ack_a: assert property (
    req & ~ack_ff |=> ack_ff ##1 ~ack_ff)
    else $error("bus answer timing wrong");

  // Counter end with no stop request, address already out
  sequence s_count_end_set;
    mod_run & mst & ~rm & ~stop_request_bit & addr_seen_ff & i_cnt_zero;
  endsequence

  register_access_ready_flag_count_a: assert property (
    s_count_end_set |=> flags_ff.register_access_ready_flag)
    else $error("count end did not set access ready");

  register_access_ready_flag_used_a: assert property (
    mod_run & i_regs_used & ~set_register_access_ready_flag |=> ~flags_ff.register_access_ready_flag)
    else $error("register use did not clear access ready");

  register_access_ready_flag_w1c_a: assert property (
    mod_run & wr_status & wdat[BIT_REGISTER_ACCESS_READY_FLAG] & ~set_register_access_ready_flag |=> ~flags_ff.register_access_ready_flag)
    else $error("access ready not cleared by write one");

  register_access_ready_flag_slave_a: assert property (
    mod_run & ~mst & ~flags_ff.register_access_ready_flag |=> ~flags_ff.register_access_ready_flag)
    else $error("access ready set outside master mode");

  transmit_ready_request_copy_a: assert property (
    mod_run & i_tx_copied |=> flags_ff.transmit_ready_request)
    else $error("transmit copy did not set ready");

  transmit_ready_request_w1c_a: assert property (
    mod_run & wr_status & wdat[BIT_TRANSMIT_READY_REQUEST] & ~i_tx_copied |=> ~flags_ff.transmit_ready_request)
    else $error("transmit ready not cleared by write one");

  receive_ready_request_w1c_a: assert property (
    mod_run & wr_status & wdat[BIT_RECEIVE_READY_REQUEST] & ~i_rx_loaded |=> ~flags_ff.receive_ready_request)
    else $error("receive ready not cleared by write one");

  receive_ready_request_hold_a: assert property (
    mod_run & flags_ff.receive_ready_request & ~clr_receive_ready_request |=> flags_ff.receive_ready_request)
    else $error("receive ready dropped without a clear");

  scd_hold_a: assert property (
    mod_run & flags_ff.stop_detected_flag & ~clr_scd |=> flags_ff.stop_detected_flag)
    else $error("stop flag dropped without a clear");

  scd_any_stop_a: assert property (
    mod_run & stop_det |=> flags_ff.stop_detected_flag)
    else $error("bus stop did not set stop flag");

  scd_module_rst_a: assert property (
    ~mod_run |=> ~flags_ff.stop_detected_flag)
    else $error("stop flag kept in module reset");

  stopgen_mode_a: assert property (
    o_stop_gen |-> $past(stop_request_bit) & ~$past(rm))
    else $error("stop issued outside non-repeat stop mode");

endmodule // i2csf_status
